// File: design/tmr_pkg.sv
// shared constants of the 8-bit timer with one compare unit
package tmr_pkg;

    // register word addresses
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_COUNT  = 3'h1;
    localparam logic [2:0] ADDR_CMP    = 3'h2;
    localparam logic [2:0] ADDR_ASYNC  = 3'h3;
    localparam logic [2:0] ADDR_FLAG   = 3'h4;
    localparam logic [2:0] ADDR_MASK   = 3'h5;

    // control register fields
    localparam int CTRL_CS_LSB   = 0;
    localparam int CTRL_CS_MSB   = 2;
    localparam int CTRL_WGM_LSB  = 3;
    localparam int CTRL_WGM_MSB  = 4;
    localparam int CTRL_COM_LSB  = 5;
    localparam int CTRL_COM_MSB  = 6;
    localparam int CTRL_FOC_BIT  = 7;

    // async status, flag and mask register fields
    localparam int ASYNC_SEL_BIT = 0;
    localparam int FLAG_CMP_BIT  = 7;
    localparam int FLAG_OVF_BIT  = 6;

    // counter landmarks and reset values
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // clock select codes
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV32   = 3'h3;
    localparam logic [2:0] CS_DIV64   = 3'h4;
    localparam logic [2:0] CS_DIV128  = 3'h5;
    localparam logic [2:0] CS_DIV256  = 3'h6;

    // prescaler tap masks, tick when all masked bits are one
    localparam logic [9:0] PSC_M8     = 10'h007;
    localparam logic [9:0] PSC_M32    = 10'h01f;
    localparam logic [9:0] PSC_M64    = 10'h03f;
    localparam logic [9:0] PSC_M128   = 10'h07f;
    localparam logic [9:0] PSC_M256   = 10'h0ff;
    localparam logic [9:0] PSC_M1024  = 10'h3ff;

    // waveform generation modes
    typedef enum logic [1:0] {
        WGM_NORMAL = 2'h0,
        WGM_PHASE  = 2'h1,
        WGM_CTC    = 2'h2,
        WGM_FAST   = 2'h3
    } tmr_wgm_t;

    // compare output mode codes
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

endpackage : tmr_pkg

// File: design/tmr_prescaler.sv
// 10-bit prescaler producing the timer tick from a source enable
`timescale 1ns/1ps
module tmr_prescaler
    import tmr_pkg::*;
#(
    parameter int PSC_W = 10
)
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // source and selection
    input  wire logic             src_tick,
    input  wire logic [2:0]       clock_select_field,
    // scaled timer tick
    output logic                  tick_ff
);

    logic [PSC_W-1:0] psc_ff;
    logic [PSC_W-1:0] tap_mask;

    // free-running divider advanced by each source tick
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            psc_ff <= '0;
        else if (src_tick)
            psc_ff <= psc_ff + 1'b1;
    end

    // tap mask for the selected division
    always_comb
    begin
        case (clock_select_field)
            CS_DIV1:   tap_mask = '0;
            CS_DIV8:   tap_mask = PSC_M8[PSC_W-1:0];
            CS_DIV32:  tap_mask = PSC_M32[PSC_W-1:0];
            CS_DIV64:  tap_mask = PSC_M64[PSC_W-1:0];
            CS_DIV128: tap_mask = PSC_M128[PSC_W-1:0];
            CS_DIV256: tap_mask = PSC_M256[PSC_W-1:0];
            default:   tap_mask = PSC_M1024[PSC_W-1:0];
        endcase
    end

    // a stopped selection never ticks, so the counter stays frozen
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            tick_ff <= 1'b0;
        else
            tick_ff <= src_tick && (clock_select_field != CS_STOP)
                       && ((psc_ff & tap_mask) == tap_mask);
    end

endmodule : tmr_prescaler

// File: design/tmr_timer8.sv
// 8-bit timer/counter with one compare unit and register port
`timescale 1ns/1ps
module tmr_timer8
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata_ff,
    // crystal oscillator pins
    input  wire logic        crystal_pin_in,
    output logic             crystal_pin_out_ff,
    // interrupt requests and service acknowledges
    input  wire logic        cmp_int_ack,
    input  wire logic        ovf_int_ack,
    output logic             cmp_irq_ff,
    output logic             ovf_irq_ff,
    // waveform output and its port override enable
    output logic             compare_output_ff,
    output logic             compare_output_en_ff
);

    // software visible state
    logic [2:0]  clock_select_field_ff;
    tmr_wgm_t    waveform_mode_field_ff;
    logic [1:0]  compare_output_mode_ff;
    logic        async_clock_select_ff;
    logic [7:0]  counter_value_ff;
    logic [7:0]  compare_value_ff;
    logic [7:0]  compare_buf_ff;
    logic        compare_match_flag_ff;
    logic        overflow_flag_ff;
    logic        compare_interrupt_enable_ff;
    logic        overflow_interrupt_enable_ff;

    // internal state
    logic        dir_down_ff;
    logic        block_ff;
    logic        xtal_prev_ff;

    // decoded strobes and conditions
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_cmp;
    logic        wr_flag;
    logic        pwm_mode;
    logic        at_bottom;
    logic        at_max;
    logic        match;
    logic        src_tick;
    logic        timer_tick;
    logic        force_cmp;

    // next values of the counter unit
    logic [7:0]  nxt_count;
    logic        nxt_dir_down;
    logic        nxt_overflow;
    logic        nxt_update_cmp;
    logic        nxt_oc;

    // register write decode
    assign wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_count = reg_wr && (reg_addr == ADDR_COUNT);
    assign wr_cmp   = reg_wr && (reg_addr == ADDR_CMP);
    assign wr_flag  = reg_wr && (reg_addr == ADDR_FLAG);

    // mode and landmark decode
    assign pwm_mode  = (waveform_mode_field_ff == WGM_PHASE) || (waveform_mode_field_ff == WGM_FAST);
    assign at_bottom = (counter_value_ff == CNT_BOTTOM);
    assign at_max    = (counter_value_ff == CNT_MAX);
    // match masked by preceding counter write
    assign match     = (counter_value_ff == compare_value_ff) && !block_ff;
    // force strobe only in non-PWM modes
    assign force_cmp = wr_ctrl && reg_wdata[CTRL_FOC_BIT] && !pwm_mode;

    // crystal edge or every io clock cycle as source
    assign src_tick = async_clock_select_ff ? (crystal_pin_in && !xtal_prev_ff) : 1'b1;

    // crystal input is taken as synchronous; edge detect on it
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            xtal_prev_ff <= 1'b0;
        else
            xtal_prev_ff <= crystal_pin_in;
    end

    // inverting feedback keeps an external resonator swinging
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            crystal_pin_out_ff <= 1'b1;
        else
            crystal_pin_out_ff <= !crystal_pin_in || !async_clock_select_ff;
    end

    tmr_prescaler #(
        .PSC_W              (10)
    ) u_prescaler (
        .clk_sys            (clk_sys),
        .nrst               (nrst),
        .src_tick           (src_tick),
        .clock_select_field (clock_select_field_ff),
        .tick_ff            (timer_tick)
    );

    // counting sequence and waveform action for one timer tick
    always_comb
    begin
        nxt_count      = counter_value_ff + CNT_ONE;
        nxt_dir_down   = dir_down_ff;
        nxt_overflow   = 1'b0;
        nxt_update_cmp = 1'b0;
        nxt_oc         = compare_output_ff;
        // mode picks clear, count up or down
        case (waveform_mode_field_ff)
            WGM_NORMAL:
            begin
                // wrap with overflow as counter becomes zero
                nxt_dir_down = 1'b0;
                nxt_overflow = at_max;
            end
            WGM_CTC:
            begin
                nxt_dir_down = 1'b0;
                nxt_overflow = at_max;
                if (match)
                    nxt_count = CNT_BOTTOM;
            end
            WGM_FAST:
            begin
                // single slope, buffer loads at max
                nxt_dir_down   = 1'b0;
                nxt_overflow   = at_max;
                nxt_update_cmp = at_max;
            end
            WGM_PHASE:
            begin
                // dual slope between bottom and max
                if (!dir_down_ff && at_max)
                begin
                    nxt_dir_down   = 1'b1;
                    nxt_update_cmp = 1'b1;
                end
                else if (dir_down_ff && at_bottom)
                begin
                    nxt_dir_down = 1'b0;
                    nxt_overflow = 1'b1;
                end
                if (nxt_dir_down)
                    nxt_count = counter_value_ff - CNT_ONE;
            end
            default:
            begin
                nxt_dir_down = 1'b0;
            end
        endcase
        // mode zero never alters output state
        if (pwm_mode)
        begin
            // non-inverting clears on up-count match; sets on down-count match, or at max in fast mode
            if (compare_output_mode_ff == COM_CLEAR || compare_output_mode_ff == COM_SET)
            begin
                if (match)
                    nxt_oc = (compare_output_mode_ff == COM_SET) ^ dir_down_ff;
                else if (waveform_mode_field_ff == WGM_FAST && at_max)
                    nxt_oc = (compare_output_mode_ff == COM_CLEAR);
            end
        end
        else if (match)
        begin
            case (compare_output_mode_ff)
                COM_TOGGLE: nxt_oc = !compare_output_ff;
                COM_CLEAR:  nxt_oc = 1'b0;
                COM_SET:    nxt_oc = 1'b1;
                default:    nxt_oc = compare_output_ff;
            endcase
        end
    end

    // control register, force strobe bit is not stored
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            clock_select_field_ff  <= CS_STOP;
            waveform_mode_field_ff <= WGM_NORMAL;
            compare_output_mode_ff <= COM_NONE;
        end
        else if (wr_ctrl)
        begin
            clock_select_field_ff  <= reg_wdata[CTRL_CS_MSB:CTRL_CS_LSB];
            waveform_mode_field_ff <= tmr_wgm_t'(reg_wdata[CTRL_WGM_MSB:CTRL_WGM_LSB]);
            // mode bits act immediately, never buffered
            compare_output_mode_ff <= reg_wdata[CTRL_COM_MSB:CTRL_COM_LSB];
        end
    end

    // async select and interrupt enables
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            async_clock_select_ff        <= 1'b0;
            compare_interrupt_enable_ff  <= 1'b0;
            overflow_interrupt_enable_ff <= 1'b0;
        end
        else
        begin
            // async select bit steers the source
            if (reg_wr && reg_addr == ADDR_ASYNC)
                async_clock_select_ff <= reg_wdata[ASYNC_SEL_BIT];
            if (reg_wr && reg_addr == ADDR_MASK)
            begin
                compare_interrupt_enable_ff  <= reg_wdata[FLAG_CMP_BIT];
                overflow_interrupt_enable_ff <= reg_wdata[FLAG_OVF_BIT];
            end
        end
    end

    // counter and direction
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            counter_value_ff <= RST_BYTE;
            dir_down_ff      <= 1'b0;
        end
        // cpu write wins over count and clear
        // write works with the clock stopped
        else if (wr_count)
            counter_value_ff <= reg_wdata;
        else if (timer_tick)
        begin
            counter_value_ff <= nxt_count;
            dir_down_ff      <= nxt_dir_down;
        end
    end

    // match blocking after a counter write
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            block_ff <= 1'b0;
        // holds until the next tick, even while stopped
        else if (wr_count)
            block_ff <= 1'b1;
        else if (timer_tick)
            block_ff <= 1'b0;
    end

    // compare buffer and active compare value
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            compare_buf_ff   <= RST_BYTE;
            compare_value_ff <= RST_BYTE;
        end
        else
        begin
            // cpu writes land in the buffer
            if (wr_cmp)
                compare_buf_ff <= reg_wdata;
            // direct in non-PWM, at max in both PWM modes
            if (wr_cmp && !pwm_mode)
                compare_value_ff <= reg_wdata;
            else if (pwm_mode && timer_tick && nxt_update_cmp)
                compare_value_ff <= compare_buf_ff;
        end
    end

    // compare output state, never reset by a mode change
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            compare_output_ff <= 1'b0;
        // force acts on the output like a non-PWM match, without setting the flag
        else if (force_cmp)
        begin
            case (reg_wdata[CTRL_COM_MSB:CTRL_COM_LSB])
                COM_TOGGLE: compare_output_ff <= !compare_output_ff;
                COM_CLEAR:  compare_output_ff <= 1'b0;
                COM_SET:    compare_output_ff <= 1'b1;
                default:    compare_output_ff <= compare_output_ff;
            endcase
        end
        // only match or fast-mode max events change it
        else if (timer_tick)
            compare_output_ff <= nxt_oc;
    end

    // port override follows the output mode bits
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            compare_output_en_ff <= 1'b0;
        else
            compare_output_en_ff <= (compare_output_mode_ff != COM_NONE);
    end

    // compare match flag, a set beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            compare_match_flag_ff <= 1'b0;
        // set on the tick that leaves the matching value
        else if (timer_tick && match)
            compare_match_flag_ff <= 1'b1;
        else if ((wr_flag && reg_wdata[FLAG_CMP_BIT]) || cmp_int_ack)
            compare_match_flag_ff <= 1'b0;
    end

    // overflow flag, same set-wins ordering
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            overflow_flag_ff <= 1'b0;
        else if (timer_tick && nxt_overflow && !wr_count)
            overflow_flag_ff <= 1'b1;
        else if ((wr_flag && reg_wdata[FLAG_OVF_BIT]) || ovf_int_ack)
            overflow_flag_ff <= 1'b0;
    end

    // interrupt requests, registered so they follow the flags
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cmp_irq_ff <= 1'b0;
            ovf_irq_ff <= 1'b0;
        end
        else
        begin
            cmp_irq_ff <= compare_interrupt_enable_ff && compare_match_flag_ff && !cmp_int_ack;
            ovf_irq_ff <= overflow_interrupt_enable_ff && overflow_flag_ff && !ovf_int_ack;
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            reg_rdata_ff <= RST_BYTE;
        else if (!reg_rd)
            reg_rdata_ff <= RST_BYTE;
        else
        begin
            reg_rdata_ff <= RST_BYTE;
            case (reg_addr)
                ADDR_CTRL:
                begin
                    reg_rdata_ff[CTRL_CS_MSB:CTRL_CS_LSB]   <= clock_select_field_ff;
                    reg_rdata_ff[CTRL_WGM_MSB:CTRL_WGM_LSB] <= waveform_mode_field_ff;
                    reg_rdata_ff[CTRL_COM_MSB:CTRL_COM_LSB] <= compare_output_mode_ff;
                end
                ADDR_COUNT: reg_rdata_ff <= counter_value_ff;
                ADDR_CMP:   reg_rdata_ff <= pwm_mode ? compare_buf_ff : compare_value_ff;
                ADDR_ASYNC: reg_rdata_ff[ASYNC_SEL_BIT] <= async_clock_select_ff;
                ADDR_FLAG:
                begin
                    reg_rdata_ff[FLAG_CMP_BIT] <= compare_match_flag_ff;
                    reg_rdata_ff[FLAG_OVF_BIT] <= overflow_flag_ff;
                end
                ADDR_MASK:
                begin
                    reg_rdata_ff[FLAG_CMP_BIT] <= compare_interrupt_enable_ff;
                    reg_rdata_ff[FLAG_OVF_BIT] <= overflow_interrupt_enable_ff;
                end
                default:    reg_rdata_ff <= RST_BYTE;
            endcase
        end
    end

endmodule : tmr_timer8

// File: dv/tmr_timer8_asserts.sv
// concurrent checks on the timer ports, bound to the top module
`timescale 1ns/1ps
module tmr_timer8_asserts
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    // pins and requests
    input wire logic       crystal_pin_in,
    input wire logic       crystal_pin_out_ff,
    input wire logic       cmp_irq_ff,
    input wire logic       ovf_irq_ff,
    input wire logic       compare_output_en_ff
);
    logic [1:0] mask_ff;
    logic       async_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // mirror of mask and async select, so irq and pin checks need no internals
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mask_ff  <= 2'h0;
            async_ff <= 1'b0;
        end
        else if (reg_wr && reg_addr == ADDR_MASK)
            mask_ff <= reg_wdata[7:6];
        else if (reg_wr && reg_addr == ADDR_ASYNC)
            async_ff <= reg_wdata[ASYNC_SEL_BIT];
    end

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_MASK |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read returned nonzero");
    chk_mask_read: assert property (reg_rd && reg_addr == ADDR_MASK |=> reg_rdata_ff[7:6] == $past(mask_ff))
        else $error("mask read differs from last write");
    chk_force_reads0: assert property (reg_rd && reg_addr == ADDR_CTRL |=> !reg_rdata_ff[CTRL_FOC_BIT])
        else $error("force strobe bit read back as one");
    chk_outen_follow: assert property (reg_wr && reg_addr == ADDR_CTRL |-> ##2
        compare_output_en_ff == ($past(reg_wdata[6:5], 2) != COM_NONE))
        else $error("output enable does not follow output mode");
    chk_outen_cause: assert property ($changed(compare_output_en_ff) |-> $past(reg_wr && reg_addr == ADDR_CTRL, 2))
        else $error("output enable changed without control write");
    chk_cmp_masked: assert property (cmp_irq_ff |-> $past(mask_ff[1]))
        else $error("compare request while disabled");
    chk_ovf_masked: assert property (ovf_irq_ff |-> $past(mask_ff[0]))
        else $error("overflow request while disabled");
    chk_xtal_out: assert property (crystal_pin_out_ff == ($past(async_ff) ? !$past(crystal_pin_in) : 1'b1))
        else $error("crystal output pin wrong");
endmodule : tmr_timer8_asserts

bind tmr_timer8 tmr_timer8_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .crystal_pin_in(crystal_pin_in), .crystal_pin_out_ff(crystal_pin_out_ff), .cmp_irq_ff(cmp_irq_ff),
    .ovf_irq_ff(ovf_irq_ff), .compare_output_en_ff(compare_output_en_ff));

// File: dv/tb_tmr_timer8.sv
// self-checking bench for the 8-bit timer with one compare unit
`timescale 1ns/1ps
module tb_tmr_timer8
    import tmr_pkg::*;
;
    typedef struct packed {logic [2:0] wa; logic [7:0] wd; logic [2:0] ra; logic [7:0] ex;} tmr_row_t;
    logic       clk_sys;
    logic       nrst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata_ff;
    logic       crystal_pin_in;
    logic       crystal_pin_out_ff;
    logic       cmp_int_ack;
    logic       ovf_int_ack;
    logic       cmp_irq_ff;
    logic       ovf_irq_ff;
    logic       compare_output_ff;
    logic       compare_output_en_ff;
    logic [7:0] rv;
    int         errors;
    int         n_tests;
    // write then read back; the force bit reads zero, unmapped reads zero
    localparam tmr_row_t ROWS [8] = '{'{ADDR_COUNT, 8'h5a, ADDR_COUNT, 8'h5a}, '{ADDR_CMP, 8'ha5, ADDR_CMP, 8'ha5},
        '{ADDR_MASK, 8'hc0, ADDR_MASK, 8'hc0}, '{ADDR_ASYNC, 8'h01, ADDR_ASYNC, 8'h01},
        '{ADDR_ASYNC, 8'h00, ADDR_ASYNC, 8'h00}, '{ADDR_CTRL, 8'h30, ADDR_CTRL, 8'h30},
        '{ADDR_CTRL, 8'h80, ADDR_CTRL, 8'h00}, '{3'h6, 8'hff, 3'h6, 8'h00}};
    // control byte, expected output state; timer stopped throughout
    localparam logic [15:0] FRC [7] = '{16'he001, 16'hc000, 16'ha001, 16'h8001, 16'h3801, 16'hd801, 16'h1801};

    tmr_timer8 DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .crystal_pin_in(crystal_pin_in),
        .crystal_pin_out_ff(crystal_pin_out_ff), .cmp_int_ack(cmp_int_ack), .ovf_int_ack(ovf_int_ack),
        .cmp_irq_ff(cmp_irq_ff), .ovf_irq_ff(ovf_irq_ff), .compare_output_ff(compare_output_ff),
        .compare_output_en_ff(compare_output_en_ff));

    // 250 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // whole run is under 1000 cycles, so 5000 means a hang
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        end_sim();
    end

    task automatic run(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : run

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata_ff;
    endtask : rd

    // one-cycle service acknowledge, compare when c is one, else overflow
    task automatic ack(input logic c);
        @(posedge clk_sys);
        cmp_int_ack <= c;
        ovf_int_ack <= !c;
        @(posedge clk_sys);
        cmp_int_ack <= 1'b0;
        ovf_int_ack <= 1'b0;
    endtask : ack

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkb(input logic seen, input logic exp);
        chk({7'h0, seen}, {7'h0, exp});
    endtask : chkb

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // main sequence; each step before the crystal one leaves the timer stopped for the next
    initial
    begin
        {nrst, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {crystal_pin_in, cmp_int_ack, ovf_int_ack, errors, n_tests} = '0;
        // release on a rising edge so the first strobe sees a settled block
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            wr(ROWS[i].wa, ROWS[i].wd);
            rd(ROWS[i].ra);
            chk(rv, ROWS[i].ex);
        end
        $display("done table");
        wr(ADDR_COUNT, 8'hfe);
        run(10);
        rd(ADDR_COUNT);
        chk(rv, 8'hfe);
        wr(ADDR_CTRL, 8'h01);
        run(8);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_FLAG);
        chk(rv & 8'h40, 8'h40);
        chkb(ovf_irq_ff, 1'b1);
        ack(1'b0);
        run(2);
        chkb(ovf_irq_ff, 1'b0);
        $display("done overflow");
        wr(ADDR_CMP, 8'h10);
        wr(ADDR_COUNT, 8'h08);
        wr(ADDR_CTRL, 8'h01);
        run(20);
        wr(ADDR_CTRL, 8'h00);
        chkb(cmp_irq_ff, 1'b1);
        wr(ADDR_FLAG, 8'h40);
        rd(ADDR_FLAG);
        chk(rv, 8'h80);
        wr(ADDR_FLAG, 8'h80);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("done match flag");
        // counter equal to compare when started: the first tick is blocked
        wr(ADDR_CMP, 8'h20);
        wr(ADDR_COUNT, 8'h20);
        wr(ADDR_CTRL, 8'h01);
        run(4);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("done blocking");
        foreach (FRC[i])
        begin
            wr(ADDR_CTRL, FRC[i][15:8]);
            run(2);
            chkb(compare_output_ff, FRC[i][0]);
        end
        chkb(compare_output_en_ff, 1'b0);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("done force");
        // fast mode: new compare waits in the buffer, old one still matches
        wr(ADDR_CMP, 8'h40);
        rd(ADDR_CMP);
        chk(rv, 8'h40);
        wr(ADDR_COUNT, 8'h1c);
        // non-inverting output: the match at the old compare clears it
        wr(ADDR_CTRL, 8'h59);
        run(8);
        wr(ADDR_CTRL, 8'h58);
        chkb(compare_output_ff, 1'b0);
        rd(ADDR_FLAG);
        chk(rv, 8'h80);
        ack(1'b1);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("done buffer");
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_CMP, 8'h03);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL, 8'h11);
        run(40);
        wr(ADDR_CTRL, 8'h10);
        rd(ADDR_COUNT);
        chkb(rv <= 8'h03, 1'b1);
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_COUNT, 8'hfc);
        wr(ADDR_CTRL, 8'h09);
        run(8);
        wr(ADDR_CTRL, 8'h08);
        rd(ADDR_COUNT);
        chkb(rv > 8'h80, 1'b1);
        // divide by 8 over about 82 source cycles: 10 or 11 ticks
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL, 8'h02);
        run(80);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_COUNT);
        chkb(rv == 8'h0a || rv == 8'h0b, 1'b1);
        $display("done modes");
        // crystal source: no pin edges, no count; then five rising edges
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_ASYNC, 8'h01);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        run(20);
        rd(ADDR_COUNT);
        chk(rv, 8'h00);
        repeat (10)
        begin
            run(2);
            @(posedge clk_sys);
            crystal_pin_in <= !crystal_pin_in;
        end
        run(6);
        rd(ADDR_COUNT);
        chk(rv, 8'h05);
        $display("done crystal");
        @(posedge clk_sys);
        nrst <= 1'b0;
        run(3);
        chkb(crystal_pin_out_ff, 1'b1);
        chkb(compare_output_ff, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rd(ADDR_COUNT);
        chk(rv, RST_BYTE);
        $display("done reset");
        end_sim();
    end
endmodule : tb_tmr_timer8
